// [hdl/bsn_exec_pkg.sv]
/*
 Constants for the borrow-subtract and nibble-exchange execution block.
 Assumes an 8-bit core with a 12-bit data memory address and a four-phase instruction cycle.
*/
package bsn_exec_pkg;

    // ****************************************
    // Opcode fields
    // ****************************************
    localparam logic [5:0] subtract_with_borrow_op = 6'h16;
    localparam logic [5:0] nibble_exchange_op = 6'h0E;
    localparam int OPC_HI = 15;
    localparam int OPC_LO = 10;
    localparam int DEST_BIT = 9;
    localparam int BANK_SEL_BIT = 8;

    // ****************************************
    // Addressing
    // ****************************************
    localparam logic [7:0] IDX_LIMIT = 8'h5F;
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;

    // ****************************************
    // Reset values and flag bit positions
    // ****************************************
    localparam logic [7:0] W_RESET = 8'h00;
    localparam logic [4:0] FLAGS_RESET = 5'h00;
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;

    // ****************************************
    // Phases
    // ****************************************
    typedef enum logic [1:0] {
        PH_DECODE = 2'b00,
        PH_READ = 2'b01,
        PH_PROCESS = 2'b11,
        PH_WRITE = 2'b10
    } phase_t;

endpackage

// [hdl/bsn_exec.sv]
/*
 Execution unit for the borrow-subtract and nibble-exchange byte instructions.
 Assumes a single-port data memory with combinational read and a write strobe; the fetch logic
 holds i_instr and i_instr_valid stable across the four phases of one instruction cycle.
*/
// Overview of operation
// - Borrow-subtract computes file minus working minus inverted carry, updating N, OV, C, DC, Z.
// - Borrow-subtract with destination one writes the difference back to the file register.
// - Nibble-exchange swaps bits 3:0 and 7:4 of the file register.
// - Nibble-exchange with destination zero writes working register, file left unchanged.
// - Extended set, bank-select zero, file field at most 95: indexed literal offset addressing.
`timescale 1ns/1ps

module bsn_exec
    import bsn_exec_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_nrst,
    input wire logic [15:0] i_instr,
    input wire logic i_instr_valid,
    input wire logic i_ext_set_en,
    input wire logic [3:0] i_bank_pointer_register,
    input wire logic [11:0] i_index_base,
    input wire logic [7:0] i_mem_rdata,
    output logic [11:0] o_mem_addr,
    output logic [7:0] o_mem_wdata,
    output logic o_mem_we,
    output logic [7:0] o_wreg,
    output logic [4:0] o_flags,
    output logic [1:0] o_phase,
    output logic o_done
);

    // ****************************************
    // Decode and address formation
    // ****************************************
    logic [5:0] opc;
    logic [7:0] ffield;
    logic dest;
    logic bsel;
    logic is_sub;
    logic is_swap;
    logic [11:0] addr_c;

    assign opc = i_instr[OPC_HI:OPC_LO];
    assign ffield = i_instr[7:0];
    assign dest = i_instr[DEST_BIT];
    assign bsel = i_instr[BANK_SEL_BIT];
    assign is_sub = i_instr_valid && (opc == subtract_with_borrow_op);
    assign is_swap = i_instr_valid && (opc == nibble_exchange_op);

    always_comb begin
        if (bsel) begin
            addr_c = {i_bank_pointer_register, ffield};
        end else if (i_ext_set_en && (ffield <= IDX_LIMIT)) begin
            addr_c = i_index_base + {4'h0, ffield};
        end else if (ffield >= ACCESS_SPLIT) begin
            addr_c = {ACCESS_HI_BANK, ffield};
        end else begin
            addr_c = {ACCESS_LO_BANK, ffield};
        end
    end

    // ****************************************
    // Phase sequencer
    // ****************************************
    phase_t phase_q;
    phase_t phase_d;
    logic [11:0] addr_q;
    logic [11:0] addr_d;
    logic done_q;
    logic done_d;

    // The sequencer waits only in decode: a recognised instruction always finishes in four phases.
    always_comb begin
        phase_d = phase_q;
        addr_d = addr_q;
        done_d = 1'b0;
        case (phase_q)
            PH_DECODE: begin
                if (is_sub || is_swap) begin
                    addr_d = addr_c;
                    phase_d = PH_READ;
                end
            end
            PH_READ: begin
                phase_d = PH_PROCESS;
            end
            PH_PROCESS: begin
                phase_d = PH_WRITE;
            end
            PH_WRITE: begin
                done_d = 1'b1;
                phase_d = PH_DECODE;
            end
            default: begin
                phase_d = PH_DECODE;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            phase_q <= PH_DECODE;
            addr_q <= 12'h000;
            done_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            addr_q <= addr_d;
            done_q <= done_d;
        end
    end

    // ****************************************
    // Datapath
    // ****************************************
    logic [7:0] opnd_q;
    logic [7:0] opnd_d;
    logic [7:0] res_q;
    logic [7:0] res_d;
    logic [4:0] nflags_q;
    logic [4:0] nflags_d;
    logic [7:0] w_q;
    logic [7:0] w_d;
    logic [4:0] flags_q;
    logic [4:0] flags_d;
    logic [7:0] wdata_q;
    logic [7:0] wdata_d;
    logic we_q;
    logic we_d;
    logic [8:0] diff;
    logic [4:0] ldiff;

    // Borrow is the inverted carry, so subtracting it means adding the carry minus one.
    assign diff = {1'b0, opnd_q} + {1'b0, ~w_q} + {8'h00, flags_q[FLAG_C]};
    assign ldiff = {1'b0, opnd_q[3:0]} + {1'b0, ~w_q[3:0]} + {4'h0, flags_q[FLAG_C]};

    // Flags are held aside until the write phase so that they change together with the destination.
    always_comb begin
        opnd_d = opnd_q;
        res_d = res_q;
        nflags_d = nflags_q;
        w_d = w_q;
        flags_d = flags_q;
        wdata_d = wdata_q;
        we_d = 1'b0;
        case (phase_q)
            PH_DECODE: begin
                opnd_d = opnd_q;
            end
            PH_READ: begin
                opnd_d = i_mem_rdata;
            end
            PH_PROCESS: begin
                if (is_sub) begin
                    res_d = diff[7:0];
                    nflags_d[FLAG_C] = diff[8];
                    nflags_d[FLAG_DC] = ldiff[4];
                    nflags_d[FLAG_Z] = (diff[7:0] == 8'h00);
                    nflags_d[FLAG_N] = diff[7];
                    nflags_d[FLAG_OV] = (opnd_q[7] != w_q[7]) && (diff[7] != opnd_q[7]);
                end else begin
                    res_d = {opnd_q[3:0], opnd_q[7:4]};
                    nflags_d = flags_q;
                end
            end
            PH_WRITE: begin
                if (dest) begin
                    wdata_d = res_q;
                    we_d = 1'b1;
                end else begin
                    w_d = res_q;
                end
                flags_d = nflags_q;
            end
            default: begin
                we_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            opnd_q <= 8'h00;
            res_q <= 8'h00;
            nflags_q <= FLAGS_RESET;
            w_q <= W_RESET;
            flags_q <= FLAGS_RESET;
            wdata_q <= 8'h00;
            we_q <= 1'b0;
        end else begin
            opnd_q <= opnd_d;
            res_q <= res_d;
            nflags_q <= nflags_d;
            w_q <= w_d;
            flags_q <= flags_d;
            wdata_q <= wdata_d;
            we_q <= we_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_mem_addr = addr_q;
    assign o_mem_wdata = wdata_q;
    assign o_mem_we = we_q;
    assign o_wreg = w_q;
    assign o_flags = flags_q;
    assign o_phase = phase_q;
    assign o_done = done_q;

endmodule

// [verif/bsn_exec_checker.sv]
/* Checker for bsn_exec. Assumes it is bound to the block and sees only its ports. */
`timescale 1ns/1ps
module bsn_exec_checker
    import bsn_exec_pkg::*;
(
    input logic i_clk,
    input logic i_nrst,
    input logic [15:0] i_instr,
    input logic i_instr_valid,
    input logic i_ext_set_en,
    input logic [3:0] i_bank_pointer_register,
    input logic [11:0] i_index_base,
    input logic [7:0] i_mem_rdata,
    input logic [11:0] o_mem_addr,
    input logic [7:0] o_mem_wdata,
    input logic o_mem_we,
    input logic [7:0] o_wreg,
    input logic [4:0] o_flags,
    input logic [1:0] o_phase,
    input logic o_done
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    logic [7:0] r, f;
    logic sb, nx, d, a, ix;
    assign r = i_mem_rdata;
    assign f = i_instr[7:0];
    assign d = i_instr[DEST_BIT];
    assign a = i_instr[BANK_SEL_BIT];
    assign ix = i_ext_set_en && !a && f <= IDX_LIMIT;
    assign sb = o_phase == 2'h0 && i_instr_valid && i_instr[15:10] == subtract_with_borrow_op;
    assign nx = o_phase == 2'h0 && i_instr_valid && i_instr[15:10] == nibble_exchange_op;
    sequence s_rpw; o_phase == 2'h1 ##1 o_phase == 2'h3 ##1 o_phase == 2'h2; endsequence
    property p_cyc; sb || nx |=> s_rpw ##1 o_done; endproperty
    a_cyc: assert property (p_cyc) else $error("phase order");
    property p_bank; (sb || nx) && a |=> o_mem_addr == {$past(i_bank_pointer_register), $past(f)}; endproperty
    a_bank: assert property (p_bank) else $error("bank address");
    property p_idx; (sb || nx) && ix |=> o_mem_addr == $past(i_index_base) + $past(f); endproperty
    a_idx: assert property (p_idx) else $error("indexed address");
    property p_swf; nx && d |-> ##4 o_mem_we && o_mem_wdata == {$past(r[3:0], 3), $past(r[7:4], 3)}; endproperty
    a_swf: assert property (p_swf) else $error("swap to file");
    property p_sww; nx && !d |-> ##4 o_done && !o_mem_we && o_flags == $past(o_flags, 4); endproperty
    a_sww: assert property (p_sww) else $error("swap to working");
    property p_sbf; sb && d |-> ##4 o_mem_we &&
        o_mem_wdata == $past(r, 3) - $past(o_wreg, 3) - !$past(o_flags[FLAG_C], 3); endproperty
    a_sbf: assert property (p_sbf) else $error("subtract to file");
    property p_sbw; sb && !d |-> ##4 !o_mem_we && o_flags[FLAG_Z] == (o_wreg == 8'h00) &&
        o_flags[FLAG_N] == o_wreg[7]; endproperty
    a_sbw: assert property (p_sbw) else $error("subtract flags");
endmodule
bind bsn_exec bsn_exec_checker bsn_exec_checker_i (.*);

// [verif/bsn_exec_tb.sv]
/* Bench for bsn_exec. Read data is held per instruction, so each run touches one address. */
`timescale 1ns/1ps
module bsn_exec_tb
    import bsn_exec_pkg::*;
;
    localparam logic [5:0] SB = subtract_with_borrow_op;
    localparam logic [5:0] NX = nibble_exchange_op;
    logic i_clk = 1'h0, i_nrst = 1'h0, i_instr_valid = 1'h0, i_ext_set_en = 1'h0;
    logic [15:0] i_instr = 16'h0000;
    logic [3:0] i_bank_pointer_register = 4'h5;
    logic [11:0] i_index_base = 12'h100, o_mem_addr;
    logic [7:0] i_mem_rdata = 8'h00, o_mem_wdata, o_wreg;
    logic o_mem_we, o_done;
    logic [4:0] o_flags;
    logic [1:0] o_phase;
    int num_errors = 0, n_compared = 0, cyc = 0;
    bsn_exec bsn_exec_i (.*);
    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) begin
        cyc <= cyc + 1;
        if (cyc == 1000) begin
            num_errors++;
            test_done;
        end
    end
    task test_done;
        if (num_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task chk(string s, logic [11:0] e, logic [11:0] v);
        n_compared++;
        if (v !== e) begin
            $display("wrong value %s expected %h seen %h", s, e, v);
            num_errors++;
        end
    endtask
    // Valid stays high between runs: the next word is taken in the done cycle.
    task run(logic [5:0] op, logic [1:0] da, logic [7:0] f, r, logic [11:0] ea, logic [7:0] ev, logic [4:0] ef);
        i_instr = {op, da, f};
        i_mem_rdata = r;
        i_instr_valid = 1'h1;
        @(negedge i_clk) chk("addr", ea, o_mem_addr);
        repeat (3) @(negedge i_clk);
        chk("result", {4'h0, ev}, {4'h0, da[1] ? o_mem_wdata : o_wreg});
        chk("flags", {7'h00, ef}, {7'h00, o_flags});
        chk("we", {11'h000, da[1]}, {11'h000, o_mem_we});
        chk("done", 12'h001, {11'h000, o_done});
    endtask
    task t_sub;
        run(SB, 2'h2, 8'h10, 8'h01, 12'h010, 8'h00, 5'h07);
        run(NX, 2'h0, 8'h10, 8'hD0, 12'h010, 8'h0D, 5'h07);
        run(SB, 2'h2, 8'h10, 8'h19, 12'h010, 8'h0C, 5'h01);
        run(NX, 2'h0, 8'h10, 8'hE0, 12'h010, 8'h0E, 5'h01);
        run(SB, 2'h2, 8'h10, 8'h03, 12'h010, 8'hF5, 5'h10);
        run(NX, 2'h0, 8'h10, 8'hA1, 12'h010, 8'h1A, 5'h10);
        run(SB, 2'h0, 8'h10, 8'h1B, 12'h010, 8'h00, 5'h07);
        run(NX, 2'h0, 8'h10, 8'h10, 12'h010, 8'h01, 5'h07);
        run(SB, 2'h0, 8'h10, 8'h80, 12'h010, 8'h7F, 5'h09);
    endtask
    task t_addr;
        i_ext_set_en = 1'h1;
        run(NX, 2'h3, 8'h23, 8'h53, 12'h523, 8'h35, 5'h09);
        run(NX, 2'h2, 8'h5F, 8'h5A, 12'h15F, 8'hA5, 5'h09);
        run(NX, 2'h2, 8'h60, 8'h0F, 12'h060, 8'hF0, 5'h09);
        run(NX, 2'h2, 8'h80, 8'hF0, 12'hF80, 8'h0F, 5'h09);
    endtask
    initial begin
        repeat (3) @(negedge i_clk);
        i_nrst = 1'h1;
        t_sub;
        t_addr;
        i_instr_valid = 1'h0;
        test_done;
    end
endmodule
